// File: shared/sxpa_consts.svh
// Constants for the six-bit port A block: offsets, fields, reset values, pin-config table
`ifndef SXPA_CONSTS_SVH
`define SXPA_CONSTS_SVH

// Register indices; byte address on APB is four times the index
`define SXPA_IDX_PIN_DATA 8'h05
`define SXPA_IDX_DIRECTION 8'h85
`define SXPA_IDX_ANALOG_CFG 8'h9F
`define SXPA_IDX_BIT_MODIFY 8'hA0

// Widths
`define SXPA_PORT_W 6
`define SXPA_PCFG_W 3
`define SXPA_IDX_W 8

// Reset values
`define SXPA_LATCH_RST 6'h00
`define SXPA_DIR_RST 6'h3F
`define SXPA_PCFG_RST 3'h0

// Special pin positions
`define SXPA_BIT_OPEN_DRAIN 4
`define SXPA_BIT_VREF 3
`define SXPA_BIT_SLAVE_SEL 5

// Field positions of the bit-modify register
`define SXPA_MOD_SET_LSB 0
`define SXPA_MOD_CLR_LSB 8

// Pin-config table: analog mask per code (bit 4 is never analog)
`define SXPA_AMASK_ALL 6'h2F
`define SXPA_AMASK_LOW4 6'h0F
`define SXPA_AMASK_LOW3 6'h0B
`define SXPA_AMASK_NONE 6'h00

`endif

// File: shared/sxpa_pkg.sv
// Types and shared decode function for the six-bit port A block
package sxpa_pkg;
  `include "sxpa_consts.svh"

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sxpa_apb_req_t;

  // Decoded pin configuration
  typedef struct packed {
    logic [`SXPA_PORT_W-1:0] analog;
    logic vref_ext;
  } sxpa_pin_cfg_t;

  // Register selected by the current address
  typedef enum logic [2:0] {
    SXPA_SEL_NONE,
    SXPA_SEL_DATA,
    SXPA_SEL_DIR,
    SXPA_SEL_CFG,
    SXPA_SEL_MOD
  } sxpa_reg_sel_t;

  // Full state of the port block
  typedef struct packed {
    logic [`SXPA_PORT_W-1:0] latch;
    logic [`SXPA_PORT_W-1:0] dir;
    logic [`SXPA_PCFG_W-1:0] pcfg;
    logic [31:0] prdata;
  } sxpa_state_t;

  // Pin-config code to analog mask and reference select
  function automatic sxpa_pin_cfg_t sxpa_decode_cfg(input logic [`SXPA_PCFG_W-1:0] code,
                                                    input logic has_adc);
    sxpa_pin_cfg_t c;
    c.analog = `SXPA_AMASK_NONE;
    c.vref_ext = 1'b0;
    if (has_adc) begin
      unique case (code[2:1])
        2'h0: c.analog = `SXPA_AMASK_ALL;
        2'h1: c.analog = `SXPA_AMASK_LOW4;
        2'h2: c.analog = `SXPA_AMASK_LOW3;
        2'h3: c.analog = `SXPA_AMASK_NONE;
      endcase
      // Odd codes hand bit 3 to the reference unless all digital
      c.vref_ext = code[0] && (code[2:1] != 2'h3);
    end
    return c;
  endfunction
endpackage

// File: rtl/sxpa_pin_cell.sv
// One port pin: driver control, open-drain option and digital read path
`timescale 1ns/100ps
module sxpa_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic pin_in,
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic analog_sel,
  input wire logic force_input,
  output logic pin_out,
  output logic pin_oe,
  output logic read_bit
);
  // Driver: direction bit 1 releases the pin, even in analog mode
  always_comb begin
    if (OPEN_DRAIN) begin
      // Only pulls low; a latched 1 releases the pin
      pin_out = 1'b0;
      pin_oe = !dir_bit && !latch_bit && !force_input;
    end else begin
      pin_out = latch_bit;
      pin_oe = !dir_bit && !force_input;
    end
  end

  // Read shows pin level; analog pins read as zero
  assign read_bit = analog_sel ? 1'b0 : pin_in;
endmodule

// File: rtl/sxpa_apb_slave.sv
// APB address decode and handshake for the port A registers
`timescale 1ns/100ps
`include "sxpa_consts.svh"
module sxpa_apb_slave
  import sxpa_pkg::*;
(
  input sxpa_pkg::sxpa_apb_req_t req,
  output sxpa_pkg::sxpa_reg_sel_t sel,
  output logic setup_rd,
  output logic access_wr,
  output logic pready,
  output logic pslverr
);
  logic [`SXPA_IDX_W-1:0] idx; // Word index from byte address
  logic aligned; // Low bits zero, upper bits zero

  assign idx = req.paddr[`SXPA_IDX_W+1:2];
  assign aligned = (req.paddr[1:0] == 2'h0) && (req.paddr[31:`SXPA_IDX_W+2] == '0);

  // Address decode; misaligned or out-of-range is unmapped
  always_comb begin
    sel = SXPA_SEL_NONE;
    if (aligned) begin
      unique case (idx)
        `SXPA_IDX_PIN_DATA: sel = SXPA_SEL_DATA;
        `SXPA_IDX_DIRECTION: sel = SXPA_SEL_DIR;
        `SXPA_IDX_ANALOG_CFG: sel = SXPA_SEL_CFG;
        `SXPA_IDX_BIT_MODIFY: sel = SXPA_SEL_MOD;
        default: sel = SXPA_SEL_NONE;
      endcase
    end
  end

  // Read data is captured in setup, so access never waits
  assign setup_rd = req.psel && !req.penable && !req.pwrite;
  assign access_wr = req.psel && req.penable && req.pwrite;
  assign pready = req.psel && req.penable;
  assign pslverr = pready && (sel == SXPA_SEL_NONE);
endmodule

// File: rtl/sxpa_port_a.sv
// Six-bit port A: data latch, direction, analog pin selection, APB registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "sxpa_consts.svh"
module sxpa_port_a
  import sxpa_pkg::*;
#(
  parameter bit HAS_ADC = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`SXPA_PORT_W-1:0] pin_in,
  output logic [`SXPA_PORT_W-1:0] pin_out,
  output logic [`SXPA_PORT_W-1:0] pin_oe,
  output logic timer_zero_ext_clock,
  input wire logic ssp_slave_select_en,
  output logic ssp_slave_select,
  output logic [`SXPA_PORT_W-1:0] adc_analog_sel,
  output logic adc_vref_ext
);
  import sxpa_pkg::*;

  // Whole state of the block and its next value
  sxpa_state_t state_reg;
  sxpa_state_t state_next;

  // Bus request bundled for the slave
  sxpa_apb_req_t req;
  sxpa_reg_sel_t sel;
  logic setup_rd; // Setup-phase read: capture read data
  logic access_wr; // Access-phase write: commit

  // Decoded pin configuration
  sxpa_pin_cfg_t cfg;

  // Per-pin controls and results
  logic [`SXPA_PORT_W-1:0] force_input; // Peripheral owns the pin
  logic [`SXPA_PORT_W-1:0] pin_read; // Digital view of the pins

  // Bit-modify request fields
  logic [`SXPA_PORT_W-1:0] mod_set;
  logic [`SXPA_PORT_W-1:0] mod_clr;

  // Bundle the bus signals
  always_comb begin
    req.psel = psel;
    req.penable = penable;
    req.pwrite = pwrite;
    req.paddr = paddr;
    req.pwdata = pwdata;
  end

  // Address decode and handshake
  sxpa_apb_slave u_slave (
    .req(req),
    .sel(sel),
    .setup_rd(setup_rd),
    .access_wr(access_wr),
    .pready(pready),
    .pslverr(pslverr)
  );

  // Pin config to analog map; without a converter all pins stay digital
  assign cfg = sxpa_decode_cfg(state_reg.pcfg, HAS_ADC);

  // Analog-capable pins go to the converter as selected
  // Bits 0..2 and 5 are plain channels; bit 3 is a channel or the reference
  always_comb begin
    adc_analog_sel = cfg.analog;
    // Reference use takes bit 3 away from the channel list
    if (cfg.vref_ext) begin
      adc_analog_sel[`SXPA_BIT_VREF] = 1'b0;
    end
  end
  assign adc_vref_ext = cfg.vref_ext;

  // Enabled slave select holds bit 5 as input; other pins free
  always_comb begin
    force_input = '0;
    force_input[`SXPA_BIT_SLAVE_SEL] = ssp_slave_select_en;
  end

  // Pin cells; bit 4 is the open-drain one
  genvar g;
  generate
    for (g = 0; g < `SXPA_PORT_W; g++) begin : g_pin
      sxpa_pin_cell #(
        .OPEN_DRAIN(g == `SXPA_BIT_OPEN_DRAIN)
      ) u_cell (
        .pin_in(pin_in[g]),
        .latch_bit(state_reg.latch[g]),
        .dir_bit(state_reg.dir[g]),
        .analog_sel(cfg.analog[g]),
        .force_input(force_input[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .read_bit(pin_read[g])
      );
    end
  endgenerate

  // Bit 4 input goes straight to timer zero; hysteresis is in the pad
  assign timer_zero_ext_clock = pin_in[`SXPA_BIT_OPEN_DRAIN];

  // Slave select comes from the pin while the serial port owns it
  assign ssp_slave_select = ssp_slave_select_en ? pin_in[`SXPA_BIT_SLAVE_SEL] : 1'b1;

  // Set and clear masks of a bit-modify write
  assign mod_set = pwdata[`SXPA_MOD_SET_LSB +: `SXPA_PORT_W];
  assign mod_clr = pwdata[`SXPA_MOD_CLR_LSB +: `SXPA_PORT_W];

  // Next-state logic: register writes and read capture
  always_comb begin
    state_next = state_reg;

    // Read data captured at setup, shown during access
    if (setup_rd) begin
      state_next.prdata = '0; // Upper bits and unmapped read zero
      unique case (sel)
        SXPA_SEL_DATA: begin
          // Pin levels, not the latch
          state_next.prdata[`SXPA_PORT_W-1:0] = pin_read;
        end
        SXPA_SEL_DIR: begin
          state_next.prdata[`SXPA_PORT_W-1:0] = state_reg.dir;
        end
        SXPA_SEL_CFG: begin
          // Absent register reads zero on a no-converter part
          if (HAS_ADC) begin
            state_next.prdata[`SXPA_PCFG_W-1:0] = state_reg.pcfg;
          end
        end
        SXPA_SEL_MOD: begin
          // Write-only action register reads zero
          state_next.prdata = '0;
        end
        SXPA_SEL_NONE: begin
          state_next.prdata = '0;
        end
      endcase
    end

    // Writes commit at the access edge only
    if (access_wr) begin
      unique case (sel)
        SXPA_SEL_DATA: begin
          // Whole-byte write into the six-bit latch; bits 7..6 dropped
          state_next.latch = pwdata[`SXPA_PORT_W-1:0];
        end
        SXPA_SEL_DIR: begin
          // Direction takes effect even on analog pins
          state_next.dir = pwdata[`SXPA_PORT_W-1:0];
        end
        SXPA_SEL_CFG: begin
          // Ignored when the converter is not built
          if (HAS_ADC) begin
            state_next.pcfg = pwdata[`SXPA_PCFG_W-1:0];
          end
        end
        SXPA_SEL_MOD: begin
          // Sample pins, modify, store to latch; a pin held low by
          // outside load can thus clear an output bit
          state_next.latch = (pin_read & ~mod_clr) | mod_set;
        end
        SXPA_SEL_NONE: begin
          // Unmapped write has no effect
          state_next.latch = state_reg.latch;
        end
      endcase
    end
  end

  // State register; reset makes every pin an input and every pin but bit 4 analog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.latch <= `SXPA_LATCH_RST;
      state_reg.dir <= `SXPA_DIR_RST;
      state_reg.pcfg <= `SXPA_PCFG_RST;
      state_reg.prdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data out of the register
  assign prdata = state_reg.prdata;
endmodule

// File: bench/sxpa_port_a_sva.sv
// Port-level checker for the port A block
`timescale 1ns/100ps
module sxpa_port_a_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] pin_in,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic timer_zero_ext_clock,
  input wire logic ssp_slave_select_en,
  input wire logic ssp_slave_select,
  input wire logic [5:0] adc_analog_sel,
  input wire logic adc_vref_ext
);
  // One clock domain, so one clocking for all
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Zero wait states promised by the slave
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  property p_dir; psel && penable && pwrite && paddr == 32'h214
    |=> pin_oe[3:0] == ~$past(pwdata[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("driver enable not from direction");
  property p_od; pin_oe[4] |-> !pin_out[4]; endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  property p_tclk; timer_zero_ext_clock == pin_in[4]; endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock not from pin 4");
  property p_ss; ssp_slave_select_en |-> !pin_oe[5] && ssp_slave_select == pin_in[5];
  endproperty
  a_ss: assert property (p_ss) else $error("slave select not owning pin 5");
  // Read captured in setup: unused bits and pins in adc_analog_sel read zero
  property p_rd; psel && !penable && !pwrite && paddr == 32'h14 |=> prdata[31:6] == 0
    && (prdata[5:0] & $past(adc_analog_sel)) == 0; endproperty
  a_rd: assert property (p_rd) else $error("data read shows analog or high bits");
  property p_rst; $rose(presetn) |-> pin_oe == 0 && adc_analog_sel == 6'h2F
    && !adc_vref_ext; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs after reset");
  property p_bad; psel && penable && paddr == 32'h300 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  property p_cfg; psel && penable && pwrite && paddr == 32'h27C && pwdata[2:0] == 3'h1
    |=> adc_vref_ext && adc_analog_sel == 6'h27; endproperty
  a_cfg: assert property (p_cfg) else $error("reference code not applied");
endmodule
bind sxpa_port_a sxpa_port_a_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .timer_zero_ext_clock(timer_zero_ext_clock),
  .ssp_slave_select_en(ssp_slave_select_en), .ssp_slave_select(ssp_slave_select),
  .adc_analog_sel(adc_analog_sel), .adc_vref_ext(adc_vref_ext));

// File: bench/sxpa_pin_board.sv
// Board model: port drivers meeting external levels
`timescale 1ns/100ps
module sxpa_pin_board (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext_level,
  output logic [5:0] pin_in
);
  // Released pins show the board level; pin 4 only ever pulls low
  always_comb begin
    pin_in = ext_level;
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end
    end
  end
endmodule

// File: bench/sxpa_port_a_bench.sv
// Self-checking bench for the port A block
`timescale 1ns/100ps
module sxpa_port_a_bench;
  import sxpa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, tclk, ssp_en, ssp_ss, vref;
  logic [5:0] pin_in, pin_out, pin_oe, asel, ext, am;
  int bad_count, n_compared;
  // Design with the converter fitted
  sxpa_port_a dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .timer_zero_ext_clock(tclk), .ssp_slave_select_en(ssp_en),
    .ssp_slave_select(ssp_ss), .adc_analog_sel(asel), .adc_vref_ext(vref));
  sxpa_pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Compare seen with expected
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready with no limit of its own, the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Closing verdict
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, ssp_en, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    ext = 6'h15;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe", pin_oe, 0);
    chk("asel", asel, 6'h2F);
    xfer(0, 32'h214, 0);
    chk("dir", rd, 32'h3F);
    xfer(0, 32'h27C, 0);
    chk("cfg", rd, 0);
    xfer(0, 32'h14, 0);
    chk("data", rd, 32'h10);
    $display("reset test done");
    // Every pin-config code
    for (int c = 0; c < 8; c++) begin
      xfer(1, 32'h27C, c);
      am = c[2:1] == 0 ? 6'h2F : c[2:1] == 1 ? 6'h0F : c[2:1] == 2 ? 6'h0B : 6'h00;
      chk("vref", vref, c[0] && c[2:1] != 3);
      chk("asel", asel, c[0] && c[2:1] != 3 ? am & 6'h37 : am);
      xfer(0, 32'h14, 0);
      chk("data", rd, ext & ~am);
    end
    $display("config test done");
    // Drive pins, then release the open-drain one
    xfer(1, 32'h14, 32'h2A);
    xfer(1, 32'h214, 32'hC0);
    chk("oe", pin_oe, 6'h3F);
    chk("out", pin_out, 6'h2A);
    xfer(0, 32'h14, 0);
    chk("data", rd, 32'h2A);
    xfer(1, 32'h14, 32'hFF);
    chk("oe", pin_oe, 6'h2F);
    xfer(0, 32'h14, 0);
    chk("data", rd, 32'h3F);
    xfer(1, 32'h280, 32'h0300);
    chk("out", pin_out, 6'h2C);
    xfer(1, 32'h27C, 0);
    chk("oe", pin_oe[3:0], 4'hF);
    xfer(1, 32'h214, 32'hFF);
    xfer(0, 32'h214, 0);
    chk("dir", rd, 32'h3F);
    $display("drive test done");
    // Shared pins: slave select and timer clock
    xfer(1, 32'h27C, 7);
    xfer(1, 32'h214, 0);
    ssp_en <= 1'b1;
    ext <= 6'h10;
    @(posedge pclk);
    chk("oe5", pin_oe[5], 0);
    chk("ss", ssp_ss, 0);
    chk("tclk", tclk, 1);
    ext <= 6'h20;
    @(posedge pclk);
    chk("ss", ssp_ss, 1);
    chk("tclk", tclk, 0);
    ssp_en <= 1'b0;
    @(posedge pclk);
    chk("oe5", pin_oe[5], 1);
    chk("ss", ssp_ss, 1);
    $display("shared pin test done");
    // Bit-modify samples the pins: released bit 4, held low outside, clears its latch bit
    xfer(1, 32'h280, 32'h01);
    chk("out", pin_out, 6'h2D);
    chk("oe", pin_oe, 6'h3F);
    $display("bit modify test done");
    // Unmapped place, then a reset in mid-run
    xfer(1, 32'h300, 32'hFF);
    chk("err", err, 1);
    xfer(0, 32'h300, 0);
    chk("err", err, 1);
    chk("rd", rd, 0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe", pin_oe, 0);
    $display("error and reset test done");
    print_verdict();
  end
endmodule
